// ==== design/cfer_consts.svh ====
`ifndef CFER_CONSTS_SVH
`define CFER_CONSTS_SVH
`define CFER_CFG_BASE_FIRST 8'h14
`define CFER_CFG_BASE_SECOND 8'h18
`define CFER_CFG_CIS_PTR 8'h28
`define CFER_CFG_CIS_AREA 8'h80
`define CFER_CIS_PTR_VALUE 32'h0000_0080
`define CFER_OFS_FLAGS 8'h00
`define CFER_OFS_MASK 8'h04
`define CFER_OFS_STATE 8'h08
`define CFER_BASE_RW_MASK 32'hFFFF_FF00
`define CFER_FLAGS_RW_MASK 32'h0000_8010
`define CFER_EMASK_RW_MASK 32'h0000_C010
`define CFER_STATE_RW_MASK 32'h0000_8010
`define CFER_BIT_GWAKE 4
`define CFER_BIT_WAKE_MASK 14
`define CFER_BIT_INTR 15
`define CFER_RESET_WORD 32'h0000_0000
`endif

// ==== design/cfer_pkg.sv ====
// Types shared by the CardBus function event register bank.
package cfer_pkg;
  typedef enum logic [1:0] {
    CFER_ACC_NONE,
    CFER_ACC_CFG,
    CFER_ACC_MEM
  } cfer_acc_t;
endpackage

// ==== design/cfer_regs.sv ====
// CardBus configuration additions and function status register bank.
`timescale 1ns/1ps
`include "cfer_consts.svh"
module cfer_regs
  import cfer_pkg::*;
#(
  parameter int CIS_WORDS = 32
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Bus-type strap pin, high for CardBus.
  input wire logic card_mode_i,
  // Configuration access.
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  // Memory access to the status window.
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [3:0] mem_be_i,
  input wire logic [31:0] mem_wdata_i,
  // Event sources from the function.
  input wire logic wake_event_i,
  input wire logic intr_event_i,
  // Answer.
  output logic ack_o,
  output logic hit_o,
  output logic [31:0] rd_data_o,
  // Status toward the function.
  output logic card_mode_o,
  output logic wake_o,
  output logic irq_o
);

  logic mode_meta;
  logic mode_sync;
  logic [31:0] base_first;
  logic [31:0] base_second;
  logic [31:0] ev_flags;
  logic [31:0] ev_mask;
  logic [31:0] pr_state;
  logic [31:0] cis_mem [CIS_WORDS];
  cfer_acc_t acc;
  logic cfg_wr;
  logic mem_wr;
  logic mem_sel;
  logic [7:0] mem_ofs;
  logic [31:0] cfg_rd;
  logic [31:0] mem_rd;
  logic cfg_hit;
  logic mem_hit;
  logic [$clog2(CIS_WORDS)-1:0] cis_idx;
  logic cis_sel;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] rw);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rw;
    merge = (old & ~m) | (wd & m);
  endfunction

  function automatic logic base_match(input logic [31:0] a, input logic [31:0] b);
    base_match = (a[31:8] == b[31:8]);
  endfunction

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end else begin
      mode_meta <= card_mode_i;
      mode_sync <= mode_meta;
    end
  end

  // Configuration wins when both requests arrive together.
  always_comb begin
    if (cfg_req_i) begin
      acc = CFER_ACC_CFG;
    end else if (mem_req_i) begin
      acc = CFER_ACC_MEM;
    end else begin
      acc = CFER_ACC_NONE;
    end
  end

  assign cfg_wr = (acc == CFER_ACC_CFG) && cfg_we_i && mode_sync;
  assign mem_ofs = mem_addr_i[7:0];
  assign mem_sel = mode_sync && (base_match(mem_addr_i, base_first) ||
                                 base_match(mem_addr_i, base_second));
  assign mem_hit = mem_sel && (mem_ofs == `CFER_OFS_FLAGS || mem_ofs == `CFER_OFS_MASK ||
                               mem_ofs == `CFER_OFS_STATE);
  assign mem_wr = (acc == CFER_ACC_MEM) && mem_we_i && mem_hit;
  assign cis_sel = cfg_addr_i >= `CFER_CFG_CIS_AREA;
  assign cis_idx = cfg_addr_i[$clog2(CIS_WORDS)+1:2];

  // Base registers keep bits 7-0 at zero whatever is written.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_first <= `CFER_RESET_WORD;
      base_second <= `CFER_RESET_WORD;
    end else if (cfg_wr) begin
      if (cfg_addr_i == `CFER_CFG_BASE_FIRST) begin
        base_first <= merge(base_first, cfg_wdata_i, cfg_be_i, `CFER_BASE_RW_MASK);
      end
      if (cfg_addr_i == `CFER_CFG_BASE_SECOND) begin
        base_second <= merge(base_second, cfg_wdata_i, cfg_be_i, `CFER_BASE_RW_MASK);
      end
    end
  end

  // The CIS area is filled by configuration writes from the loader.
  always_ff @(posedge sys_clk_i) begin
    if (cfg_wr && cis_sel) begin
      cis_mem[cis_idx] <= cfg_wdata_i;
    end
  end

  // Flags clear on a written one; a new event in the same cycle wins.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_flags <= `CFER_RESET_WORD;
    end else begin
      if (mem_wr && mem_ofs == `CFER_OFS_FLAGS) begin
        ev_flags <= ev_flags & ~merge(32'h0000_0000, mem_wdata_i, mem_be_i,
                                      `CFER_FLAGS_RW_MASK);
      end
      if (wake_event_i) begin
        ev_flags[`CFER_BIT_GWAKE] <= 1'b1;
      end
      if (intr_event_i) begin
        ev_flags[`CFER_BIT_INTR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_mask <= `CFER_RESET_WORD;
    end else if (mem_wr && mem_ofs == `CFER_OFS_MASK) begin
      ev_mask <= merge(ev_mask, mem_wdata_i, mem_be_i, `CFER_EMASK_RW_MASK);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pr_state <= `CFER_RESET_WORD;
    end else if (mem_wr && mem_ofs == `CFER_OFS_STATE) begin
      pr_state <= merge(pr_state, mem_wdata_i, mem_be_i, `CFER_STATE_RW_MASK);
    end
  end

  // In PCI mode the CardBus additions read as zero and do not claim.
  always_comb begin
    cfg_rd = `CFER_RESET_WORD;
    cfg_hit = 1'b0;
    if (mode_sync) begin
      if (cis_sel) begin
        cfg_rd = cis_mem[cis_idx];
        cfg_hit = 1'b1;
      end else if (cfg_addr_i == `CFER_CFG_BASE_FIRST) begin
        cfg_rd = base_first & `CFER_BASE_RW_MASK;
        cfg_hit = 1'b1;
      end else if (cfg_addr_i == `CFER_CFG_BASE_SECOND) begin
        cfg_rd = base_second & `CFER_BASE_RW_MASK;
        cfg_hit = 1'b1;
      end else if (cfg_addr_i == `CFER_CFG_CIS_PTR) begin
        cfg_rd = `CFER_CIS_PTR_VALUE;
        cfg_hit = 1'b1;
      end
    end
  end

  always_comb begin
    mem_rd = `CFER_RESET_WORD;
    if (mem_hit) begin
      unique case (mem_ofs)
        `CFER_OFS_FLAGS: mem_rd = ev_flags & `CFER_FLAGS_RW_MASK;
        `CFER_OFS_MASK: mem_rd = ev_mask & `CFER_EMASK_RW_MASK;
        `CFER_OFS_STATE: mem_rd = pr_state & `CFER_STATE_RW_MASK;
        default: mem_rd = `CFER_RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      hit_o <= 1'b0;
      rd_data_o <= `CFER_RESET_WORD;
    end else begin
      ack_o <= (acc != CFER_ACC_NONE);
      unique case (acc)
        CFER_ACC_CFG: begin
          hit_o <= cfg_hit;
          rd_data_o <= cfg_rd;
        end
        CFER_ACC_MEM: begin
          hit_o <= mem_hit;
          rd_data_o <= mem_rd;
        end
        CFER_ACC_NONE: begin
          hit_o <= 1'b0;
          rd_data_o <= `CFER_RESET_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      card_mode_o <= 1'b0;
      wake_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      card_mode_o <= mode_sync;
      wake_o <= ev_flags[`CFER_BIT_GWAKE] & ev_mask[`CFER_BIT_GWAKE] &
                ev_mask[`CFER_BIT_WAKE_MASK];
      irq_o <= ev_flags[`CFER_BIT_INTR] & ev_mask[`CFER_BIT_INTR];
    end
  end

  AST_BASE_LOW_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (base_first[7:0] == 8'h00) && (base_second[7:0] == 8'h00))
    else $error("base low byte not zero");

  AST_BASE_WRITE_TAKES: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cfg_wr && cfg_addr_i == `CFER_CFG_BASE_FIRST && (&cfg_be_i)
    |=> base_first[31:8] == $past(cfg_wdata_i[31:8]))
    else $error("base write lost");

  AST_WINDOW_DECODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    acc == CFER_ACC_MEM && mode_sync && base_match(mem_addr_i, base_second) &&
    mem_ofs == `CFER_OFS_STATE |=> hit_o && ack_o)
    else $error("status window not decoded");

  AST_LOW_BITS_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(acc == CFER_ACC_MEM) |-> rd_data_o[3:0] == 4'h0)
    else $error("unused low bits read nonzero");

  AST_EVENT_SETS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    intr_event_i |=> ev_flags[`CFER_BIT_INTR] ##1 irq_o == $past(ev_mask[`CFER_BIT_INTR]))
    else $error("interrupt event not recorded");

  AST_FLAGS_RESERVED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(mem_hit && acc == CFER_ACC_MEM && mem_ofs == `CFER_OFS_FLAGS)
    |-> (rd_data_o & ~`CFER_FLAGS_RW_MASK) == 32'h0000_0000)
    else $error("flag reserved bits nonzero");

  AST_MASK_FIXED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ev_mask & ~`CFER_EMASK_RW_MASK) == 32'h0000_0000)
    else $error("mask fixed bits nonzero");

  AST_AUDIO_MASK_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(acc == CFER_ACC_MEM && mem_ofs == `CFER_OFS_MASK) |-> rd_data_o[6:5] == 2'b00)
    else $error("audio mask bits nonzero");

  AST_STATE_FIXED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (pr_state & ~`CFER_STATE_RW_MASK) == 32'h0000_0000)
    else $error("state fixed bits nonzero");

  AST_RO_WRITE_IGNORED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    mem_wr && mem_ofs == `CFER_OFS_STATE |=> pr_state[14:5] == 10'h000)
    else $error("reserved write stored");

  AST_PCI_MODE_HIDDEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    acc == CFER_ACC_CFG && !mode_sync |=> !hit_o && rd_data_o == 32'h0000_0000)
    else $error("CardBus header visible in PCI mode");

  COV_CIS_PTR_READ: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    acc == CFER_ACC_CFG && mode_sync && cfg_addr_i == `CFER_CFG_CIS_PTR);
  COV_FLAG_CLEAR: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    mem_wr && mem_ofs == `CFER_OFS_FLAGS && ev_flags[`CFER_BIT_INTR]);
  COV_SET_AND_CLEAR: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    mem_wr && mem_ofs == `CFER_OFS_FLAGS && wake_event_i);
  COV_IRQ: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) irq_o);

endmodule

// ==== bench/cfer_host.sv ====
// Host bridge model that issues configuration and memory cycles.
`timescale 1ns/1ps
module cfer_host (
  // Clock.
  input wire logic sys_clk_i,
  // Answer from the register bank.
  input wire logic ack_i,
  input wire logic hit_i,
  input wire logic [31:0] rd_data_i,
  // Request lines.
  output logic cfg_req_o,
  output logic mem_req_o,
  output logic we_o,
  output logic [31:0] addr_o,
  output logic [31:0] wdata_o
);
  initial begin
    cfg_req_o = 1'b0;
    mem_req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 32'h0;
    wdata_o = 32'h0;
  end
  // One request pulse; the answer is taken half a cycle after the taking edge.
  task automatic access(input logic mem, input logic we, input logic [31:0] a,
      input logic [31:0] wd, output logic ack, output logic hit, output logic [31:0] rd);
    @(negedge sys_clk_i);
    cfg_req_o = !mem;
    mem_req_o = mem;
    we_o = we;
    addr_o = a;
    wdata_o = wd;
    @(negedge sys_clk_i);
    ack = ack_i;
    hit = hit_i;
    rd = rd_data_i;
    cfg_req_o = 1'b0;
    mem_req_o = 1'b0;
    // Released lines flip so a stale value cannot pass for a held one.
    addr_o = ~a;
    wdata_o = ~wd;
  endtask
endmodule

// ==== bench/cardbus_function_event_regs_test.sv ====
// Self-checking testbench of the function event register bank.
`timescale 1ns/1ps
module cardbus_function_event_regs_test;
  localparam logic [31:0] B1 = 32'h1234_5600;
  localparam logic [31:0] B2 = 32'hABCD_EF00;
  logic sys_clk_i, rst_n_i, card_mode_i, wake_event_i, intr_event_i;
  logic cfg_req, mem_req, we, ack, hit, card_mode_o, wake_o, irq_o;
  logic [31:0] addr, wdata, rd_data;
  int fails = 0;
  int cmp_count = 0;
  cfer_host i_host (.sys_clk_i, .ack_i(ack), .hit_i(hit), .rd_data_i(rd_data),
    .cfg_req_o(cfg_req), .mem_req_o(mem_req), .we_o(we), .addr_o(addr), .wdata_o(wdata));
  cfer_regs i_dut (.sys_clk_i, .rst_n_i, .card_mode_i, .cfg_req_i(cfg_req), .cfg_we_i(we),
    .cfg_addr_i(addr[7:0]), .cfg_be_i(4'hF), .cfg_wdata_i(wdata), .mem_req_i(mem_req),
    .mem_we_i(we), .mem_addr_i(addr), .mem_be_i(4'hF), .mem_wdata_i(wdata),
    .wake_event_i, .intr_event_i, .ack_o(ack), .hit_o(hit), .rd_data_o(rd_data),
    .card_mode_o, .wake_o, .irq_o);
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access whose acknowledge and hit flag are judged, and its read data on a read.
  task automatic xfer(input logic m, input logic w, input logic [31:0] a,
      input logic [31:0] wd, input logic h, input logic [31:0] exp);
    logic k;
    logic g;
    logic [31:0] r;
    i_host.access(m, w, a, wd, k, g, r);
    chk({31'h0, k}, 32'h1);
    chk({31'h0, g}, {31'h0, h});
    if (!w) chk(r, exp);
  endtask
  task automatic pulse(input bit intr);
    @(negedge sys_clk_i);
    if (intr) intr_event_i = 1'b1;
    else wake_event_i = 1'b1;
    @(negedge sys_clk_i);
    intr_event_i = 1'b0;
    wake_event_i = 1'b0;
  endtask
  task automatic test_base();
    xfer(0, 0, 32'h14, 0, 1, 32'h0);
    xfer(0, 1, 32'h14, 32'hFFFF_FFFF, 1, 0);
    xfer(0, 0, 32'h14, 0, 1, 32'hFFFF_FF00);
    xfer(0, 1, 32'h18, 32'h5555_5555, 1, 0);
    xfer(0, 0, 32'h18, 0, 1, 32'h5555_5500);
    xfer(0, 0, 32'h28, 0, 1, 32'h0000_0080);
    xfer(0, 1, 32'h80, 32'h1357_9BDF, 1, 0);
    xfer(0, 1, 32'hFC, 32'h2468_ACE0, 1, 0);
    xfer(0, 0, 32'h80, 0, 1, 32'h1357_9BDF);
    xfer(0, 0, 32'hFC, 0, 1, 32'h2468_ACE0);
    $display("test_base done");
  endtask
  task automatic test_window();
    xfer(0, 1, 32'h14, B1, 1, 0);
    xfer(0, 1, 32'h18, B2, 1, 0);
    xfer(1, 0, B1, 0, 1, 32'h0);
    xfer(1, 1, B1 + 4, 32'hFFFF_FFFF, 1, 0);
    xfer(1, 0, B2 + 4, 0, 1, 32'h0000_C010);
    xfer(1, 1, B2 + 8, 32'hFFFF_FFFF, 1, 0);
    xfer(1, 0, B1 + 8, 0, 1, 32'h0000_8010);
    xfer(1, 0, B1 + 12, 0, 0, 32'h0);
    $display("test_window done");
  endtask
  task automatic test_events();
    pulse(0);
    xfer(1, 0, B1, 0, 1, 32'h0000_0010);
    pulse(1);
    xfer(1, 0, B2, 0, 1, 32'h0000_8010);
    chk({30'h0, wake_o, irq_o}, 32'h3);
    xfer(1, 1, B1, 32'hFFFF_FFFF, 1, 0);
    xfer(1, 0, B1, 0, 1, 32'h0);
    chk({30'h0, wake_o, irq_o}, 32'h0);
    // A clear and a new wake-up event in the same cycle: the event must survive.
    fork
      xfer(1, 1, B1, 32'hFFFF_FFFF, 1, 0);
      pulse(0);
    join
    xfer(1, 0, B1, 0, 1, 32'h0000_0010);
    $display("test_events done");
  endtask
  task automatic test_pci();
    card_mode_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk({31'h0, card_mode_o}, 32'h0);
    xfer(0, 0, 32'h14, 0, 0, 32'h0);
    xfer(1, 0, B1 + 4, 0, 0, 32'h0);
    $display("test_pci done");
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    finish_test();
  end
  initial begin
    rst_n_i = 1'b0;
    card_mode_i = 1'b1;
    wake_event_i = 1'b0;
    intr_event_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    test_base();
    test_window();
    test_events();
    test_pci();
    finish_test();
  end
endmodule
